/* File: core/serial_rx_core.sv */
// Serial receiver with sleep/wakeup, flags, loop modes and a transmit FIFO
`timescale 1ns/1ps

module serial_tx_fifo #(
  parameter int unsigned WIDTH = serial_rx_pkg::TX_DATA_W,
  parameter int unsigned DEPTH = serial_rx_pkg::TX_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
    logic                        full;
    logic                        empty;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;
  logic        push;
  logic        pop;

  always_comb
  begin
    d = q;
    push = in_valid_i && !q.full;
    pop = out_ready_i && !q.empty;
    if (push)
    begin
      d.mem[q.wr[AW-1:0]] = in_data_i;
      d.wr = q.wr + 1'b1;
    end
    if (pop)
    begin
      d.rd = q.rd + 1'b1;
    end
    d.empty = (d.wr == d.rd);
    d.full = (d.wr[AW-1:0] == d.rd[AW-1:0]) && (d.wr[AW] != d.rd[AW]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.empty <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign in_ready_o = !q.full;
  assign out_valid_o = !q.empty;
  assign out_data_o = q.mem[q.rd[AW-1:0]];
endmodule : serial_tx_fifo

module serial_rx_core #(
  parameter int unsigned FIFO_DEPTH = serial_rx_pkg::TX_DEPTH
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    sample_tick_i,
  input  wire logic                    stop_i,
  input  wire serial_rx_pkg::ctrl_t    ctrl_i,
  input  wire serial_rx_pkg::irq_en_t  irq_en_i,
  input  wire logic                    rx_sleep_set_i,
  input  wire logic                    status_read_i,
  input  wire logic                    data_read_i,
  input  wire logic                    rx_edge_clear_i,
  input  wire logic                    tx_valid_i,
  input  wire logic [7:0]              tx_data_i,
  output logic                         tx_ready_o,
  input  wire logic                    rxd_i,
  input  wire logic                    txd_pin_i,
  output logic                         txd_o,
  output logic                         txd_oe_o,
  output logic                         rxd_released_o,
  output logic [8:0]                   rx_data_o,
  output serial_rx_pkg::flags_t        flags_o,
  output logic                         rx_sleep_o,
  output logic                         tx_irq_o,
  output logic                         rx_irq_o,
  output logic                         err_irq_o,
  output logic                         wake_o
);

  typedef struct packed {
    serial_rx_pkg::rx_state_t rxs;
    logic [3:0]               rt;
    logic [3:0]               bitn;
    logic [2:0]               hist;
    logic [1:0]               cnt;
    logic                     noise;
    logic [8:0]               shift;
    logic [3:0]               idle_cnt;
    logic                     skip;
    logic                     quiet_armed;
    logic                     rx_sleep;
    serial_rx_pkg::flags_t    fl;
    logic                     seen_full;
    logic                     seen_quiet;
    logic [8:0]               rx_data;
    logic                     rx_prev;
    serial_rx_pkg::tx_state_t txs;
    logic [3:0]               trt;
    logic [3:0]               tbit;
    logic [10:0]              tsh;
    logic                     tx_line;
    logic                     pre_pend;
    logic                     tx_on_prev;
    logic                     txd_oe;
    logic                     released;
    logic                     tx_irq;
    logic                     rx_irq;
    logic                     err_irq;
    logic                     wake;
  } core_state_t;

  function automatic logic majority(input logic [1:0] n);
    majority = (n >= serial_rx_pkg::MAJ_MIN);
  endfunction : majority

  function automatic logic [3:0] char_len(input logic nine);
    char_len = nine ? serial_rx_pkg::CHAR_LEN_9 : serial_rx_pkg::CHAR_LEN_8;
  endfunction : char_len

  function automatic logic [3:0] data_bits(input logic nine);
    data_bits = nine ? serial_rx_pkg::DATA_BITS_9 : serial_rx_pkg::DATA_BITS_8;
  endfunction : data_bits

  function automatic logic [3:0] sat_inc(input logic [3:0] v, input logic nine);
    sat_inc = (v >= char_len(nine)) ? v : v + 4'h1;
  endfunction : sat_inc

  core_state_t q;
  core_state_t d;
  logic        rx_in;
  logic        edge_seen;
  logic [1:0]  n3;
  logic        b;
  logic [8:0]  word;
  logic        fe;
  logic        fifo_valid;
  logic [7:0]  fifo_data;
  logic        fifo_pop;
  logic        fifo_ready;

  serial_tx_fifo #(
    .WIDTH (serial_rx_pkg::TX_DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (tx_valid_i && !stop_i),
    .in_ready_o  (fifo_ready),
    .in_data_i   (tx_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  // Receiver input source
  always_comb
  begin
    if (!ctrl_i.loop_enable)
    begin
      rx_in = rxd_i;
    end
    else if (!ctrl_i.rx_source_select)
    begin
      rx_in = q.tx_line;
    end
    else
    begin
      rx_in = ctrl_i.single_wire_direction ? q.tx_line : txd_pin_i;
    end
  end

  assign edge_seen = ctrl_i.rx_on && q.rx_prev && !rx_in;

  always_comb
  begin
    d = q;
    fifo_pop = 1'b0;
    n3 = q.cnt + {1'b0, rx_in};
    b = majority(n3);
    word = ctrl_i.nine_bit ? q.shift : {1'b0, q.shift[8:1]};
    fe = !b;
    d.rx_prev = rx_in;
    d.tx_on_prev = ctrl_i.tx_on;
    if (ctrl_i.tx_on && !q.tx_on_prev)
    begin
      d.pre_pend = 1'b1;
    end

    // Software side
    if (rx_sleep_set_i)
    begin
      d.rx_sleep = 1'b1;
    end
    if (status_read_i)
    begin
      d.seen_full = q.fl.rx_buffer_full_flag;
      d.seen_quiet = q.fl.line_quiet_flag;
    end
    if (data_read_i)
    begin
      if (q.seen_full)
      begin
        d.fl.rx_buffer_full_flag = 1'b0;
        d.fl.overrun_flag = 1'b0;
        d.fl.noise_flag = 1'b0;
        d.fl.framing_error_flag = 1'b0;
        d.fl.parity_error_flag = 1'b0;
        d.fl.lin_break_detect_flag = 1'b0;
      end
      if (q.seen_quiet)
      begin
        d.fl.line_quiet_flag = 1'b0;
      end
      d.seen_full = 1'b0;
      d.seen_quiet = 1'b0;
    end
    if (rx_edge_clear_i)
    begin
      d.fl.rx_edge_flag = 1'b0;
    end
    if (tx_valid_i && fifo_ready)
    begin
      d.fl.tx_done_flag = 1'b0;
    end
    if (edge_seen && !q.rx_sleep)
    begin
      d.fl.rx_edge_flag = 1'b1;
    end

    // Receiver, one step per sixteenth of a bit
    if (sample_tick_i && ctrl_i.rx_on)
    begin
      d.hist = {q.hist[1:0], rx_in};
      d.rt = q.rt + 4'h1;
      case (q.rxs)
        serial_rx_pkg::RX_IDLE:
        begin
          if (q.hist == 3'b111 && !rx_in)
          begin
            d.rxs = serial_rx_pkg::RX_START;
            d.rt = 4'h1;
            d.cnt = 2'h0;
            d.noise = 1'b0;
          end
          else if (q.rt == serial_rx_pkg::RT_LAST)
          begin
            if (q.skip)
            begin
              d.skip = 1'b0;
            end
            else if (rx_in)
            begin
              d.idle_cnt = sat_inc(q.idle_cnt, ctrl_i.nine_bit);
            end
            else
            begin
              d.idle_cnt = 4'h0;
            end
            if (!q.skip && rx_in && d.idle_cnt == char_len(ctrl_i.nine_bit)
                && q.idle_cnt != d.idle_cnt)
            begin
              if (q.rx_sleep && !ctrl_i.wake_method)
              begin
                d.rx_sleep = 1'b0;
              end
              if (q.quiet_armed
                  && (!q.rx_sleep || ctrl_i.sleep_quiet_detect_enable))
              begin
                d.fl.line_quiet_flag = 1'b1;
                d.quiet_armed = 1'b0;
              end
            end
          end
        end
        serial_rx_pkg::RX_START:
        begin
          if ((q.rt == serial_rx_pkg::RT_START_A || q.rt == serial_rx_pkg::RT_START_B)
              && !rx_in)
          begin
            d.cnt = q.cnt + 2'h1;
          end
          if (q.rt == serial_rx_pkg::RT_START_C)
          begin
            if (!majority(q.cnt + {1'b0, !rx_in}))
            begin
              d.rxs = serial_rx_pkg::RX_IDLE;
            end
            d.cnt = 2'h0;
          end
          if (q.rt == serial_rx_pkg::RT_LAST)
          begin
            d.rxs = serial_rx_pkg::RX_DATA;
            d.bitn = 4'h0;
            d.idle_cnt = 4'h0;
          end
        end
        serial_rx_pkg::RX_DATA:
        begin
          if (q.rt >= serial_rx_pkg::RT_MID_A && q.rt < serial_rx_pkg::RT_MID_C)
          begin
            d.cnt = n3;
          end
          if (q.rt == serial_rx_pkg::RT_MID_C)
          begin
            d.cnt = 2'h0;
            if (n3 != 2'h0 && n3 != serial_rx_pkg::ALL_SAMPLES)
            begin
              d.noise = 1'b1;
            end
            d.shift = {b, q.shift[8:1]};
            if (!ctrl_i.quiet_count_start_select && b)
            begin
              d.idle_cnt = sat_inc(q.idle_cnt, ctrl_i.nine_bit);
            end
            else
            begin
              d.idle_cnt = 4'h0;
            end
            if (q.bitn == data_bits(ctrl_i.nine_bit) - 4'h1 && b
                && ctrl_i.wake_method && q.rx_sleep)
            begin
              d.rx_sleep = 1'b0;
            end
          end
          if (q.rt == serial_rx_pkg::RT_LAST)
          begin
            d.bitn = q.bitn + 4'h1;
            if (q.bitn == data_bits(ctrl_i.nine_bit) - 4'h1)
            begin
              d.rxs = serial_rx_pkg::RX_STOP;
            end
          end
        end
        serial_rx_pkg::RX_STOP:
        begin
          if (q.rt >= serial_rx_pkg::RT_MID_A && q.rt < serial_rx_pkg::RT_MID_C)
          begin
            d.cnt = n3;
          end
          if (q.rt == serial_rx_pkg::RT_MID_C)
          begin
            d.cnt = 2'h0;
            d.rxs = serial_rx_pkg::RX_IDLE;
            d.skip = ctrl_i.quiet_count_start_select;
            if (ctrl_i.quiet_count_start_select)
            begin
              d.idle_cnt = 4'h0;
            end
            // Framing error holds off new characters until cleared
            if (!q.rx_sleep && !q.fl.framing_error_flag)
            begin
              if (d.fl.rx_buffer_full_flag)
              begin
                d.fl.overrun_flag = 1'b1;
              end
              else
              begin
                d.fl.rx_buffer_full_flag = 1'b1;
                d.rx_data = word;
                d.quiet_armed = 1'b1;
                d.fl.noise_flag = q.noise
                                || (n3 != 2'h0 && n3 != serial_rx_pkg::ALL_SAMPLES);
                d.fl.framing_error_flag = fe;
                d.fl.parity_error_flag = ctrl_i.parity_en && (^word);
                d.fl.lin_break_detect_flag = fe && (word == 9'h000);
              end
            end
          end
        end
        default:
        begin
          d.rxs = serial_rx_pkg::RX_IDLE;
        end
      endcase
    end
    if (!ctrl_i.rx_on)
    begin
      d.rxs = serial_rx_pkg::RX_IDLE;
    end

    // Transmitter
    if (sample_tick_i)
    begin
      case (q.txs)
        serial_rx_pkg::TX_IDLE:
        begin
          d.trt = 4'h0;
          d.tbit = char_len(ctrl_i.nine_bit);
          if (ctrl_i.tx_on && q.pre_pend)
          begin
            d.tsh = '1;
            d.pre_pend = 1'b0;
            d.txs = serial_rx_pkg::TX_SHIFT;
          end
          else if (ctrl_i.tx_on && fifo_valid)
          begin
            fifo_pop = !stop_i;
            d.tsh = {1'b1, ctrl_i.nine_bit ? ctrl_i.tx_ninth_bit : 1'b1,
                     fifo_data, 1'b0};
            d.txs = serial_rx_pkg::TX_SHIFT;
          end
          else if (!fifo_valid && !q.pre_pend)
          begin
            d.fl.tx_done_flag = 1'b1;
          end
        end
        serial_rx_pkg::TX_SHIFT:
        begin
          d.trt = q.trt + 4'h1;
          if (q.trt == serial_rx_pkg::RT_LAST)
          begin
            d.tsh = {1'b1, q.tsh[10:1]};
            d.tbit = q.tbit - 4'h1;
            if (q.tbit == 4'h1)
            begin
              d.txs = serial_rx_pkg::TX_IDLE;
            end
          end
        end
        default:
        begin
          d.txs = serial_rx_pkg::TX_IDLE;
        end
      endcase
    end
    if (d.txs != serial_rx_pkg::TX_IDLE)
    begin
      d.fl.tx_done_flag = 1'b0;
    end
    d.tx_line = (d.txs == serial_rx_pkg::TX_SHIFT) ? d.tsh[0] : 1'b1;
    d.fl.tx_buffer_empty_flag = fifo_ready;

    // Pins
    d.txd_oe = !(ctrl_i.loop_enable && ctrl_i.rx_source_select
                 && !ctrl_i.single_wire_direction);
    d.released = ctrl_i.loop_enable;

    // Freeze everything but the edge detector while stopped
    d.wake = 1'b0;
    if (stop_i)
    begin
      d = q;
      fifo_pop = 1'b0;
      d.rx_prev = rx_in;
      d.wake = 1'b0;
      if (edge_seen)
      begin
        d.fl.rx_edge_flag = 1'b1;
        d.wake = irq_en_i.rx_edge;
      end
    end

    // Interrupt grouping
    d.tx_irq = (d.fl.tx_buffer_empty_flag && irq_en_i.tx_empty)
             || (d.fl.tx_done_flag && irq_en_i.tx_done);
    d.rx_irq = (d.fl.rx_buffer_full_flag && irq_en_i.rx_full)
             || (d.fl.line_quiet_flag && irq_en_i.quiet)
             || (d.fl.rx_edge_flag && irq_en_i.rx_edge)
             || (d.fl.lin_break_detect_flag && irq_en_i.lin_break);
    d.err_irq = (d.fl.overrun_flag && irq_en_i.overrun)
              || (d.fl.noise_flag && irq_en_i.noise)
              || (d.fl.framing_error_flag && irq_en_i.framing)
              || (d.fl.parity_error_flag && irq_en_i.parity);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.tx_line <= 1'b1;
      q.rx_prev <= 1'b1;
      // Idle line history, so the first start bit is seen
      q.hist <= '1;
      q.txd_oe <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign tx_ready_o = fifo_ready;
  assign txd_o = q.tx_line;
  assign txd_oe_o = q.txd_oe;
  assign rxd_released_o = q.released;
  assign rx_data_o = q.rx_data;
  assign flags_o = q.fl;
  assign rx_sleep_o = q.rx_sleep;
  assign tx_irq_o = q.tx_irq;
  assign rx_irq_o = q.rx_irq;
  assign err_irq_o = q.err_irq;
  assign wake_o = q.wake;

endmodule : serial_rx_core

/* File: core/serial_rx_pkg.sv */
// Shared constants and carriers of the serial receiver and flag block
package serial_rx_pkg;

  // Sixteenth of a bit, counted from zero (RT1 = 0)
  localparam logic [3:0] RT_LAST     = 4'hf;
  localparam logic [3:0] RT_START_A  = 4'h2;
  localparam logic [3:0] RT_START_B  = 4'h4;
  localparam logic [3:0] RT_START_C  = 4'h6;
  localparam logic [3:0] RT_MID_A    = 4'h7;
  localparam logic [3:0] RT_MID_C    = 4'h9;

  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam logic [3:0] CHAR_LEN_8  = 4'ha;
  localparam logic [3:0] CHAR_LEN_9  = 4'hb;

  localparam int unsigned TX_DATA_W  = 8;
  localparam int unsigned TX_DEPTH   = 16;

  localparam logic [1:0] MAJ_MIN     = 2'h2;
  localparam logic [1:0] ALL_SAMPLES = 2'h3;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

  typedef enum logic [0:0] {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } tx_state_t;

  typedef struct packed {
    logic rx_on;
    logic tx_on;
    logic nine_bit;
    logic wake_method;
    logic sleep_quiet_detect_enable;
    logic quiet_count_start_select;
    logic loop_enable;
    logic rx_source_select;
    logic single_wire_direction;
    logic tx_ninth_bit;
    logic parity_en;
  } ctrl_t;

  typedef struct packed {
    logic tx_empty;
    logic tx_done;
    logic rx_full;
    logic quiet;
    logic rx_edge;
    logic lin_break;
    logic overrun;
    logic noise;
    logic framing;
    logic parity;
  } irq_en_t;

  typedef struct packed {
    logic tx_buffer_empty_flag;
    logic tx_done_flag;
    logic rx_buffer_full_flag;
    logic line_quiet_flag;
    logic rx_edge_flag;
    logic lin_break_detect_flag;
    logic overrun_flag;
    logic noise_flag;
    logic framing_error_flag;
    logic parity_error_flag;
  } flags_t;

endpackage : serial_rx_pkg

/* File: dv/serial_rx_asserts.sv */
// Port-level checks of the serial receiver core
`timescale 1ns/1ps
module serial_rx_asserts (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   stop_i,
  input wire serial_rx_pkg::ctrl_t   ctrl_i,
  input wire serial_rx_pkg::irq_en_t irq_en_i,
  input wire logic                   data_read_i,
  input wire logic                   rx_edge_clear_i,
  input wire logic                   txd_oe_o,
  input wire logic                   rxd_released_o,
  input wire logic [8:0]             rx_data_o,
  input wire serial_rx_pkg::flags_t  flags_o,
  input wire logic                   rx_sleep_o,
  input wire logic                   tx_irq_o,
  input wire logic                   rx_irq_o,
  input wire logic                   err_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_TX_IRQ: assert property (!$past(rst_i) && !$past(stop_i) |->
    tx_irq_o == |(flags_o[9:8] & $past(irq_en_i[9:8]))) else $error("tx irq wrong");
  AST_RX_IRQ: assert property (!$past(rst_i) && !$past(stop_i) |->
    rx_irq_o == |(flags_o[7:4] & $past(irq_en_i[7:4]))) else $error("rx irq wrong");
  AST_ERR_IRQ: assert property (!$past(rst_i) && !$past(stop_i) |->
    err_irq_o == |(flags_o[3:0] & $past(irq_en_i[3:0]))) else $error("err irq wrong");
  AST_FULL_AWAKE: assert property ($rose(flags_o.rx_buffer_full_flag) |->
    !$past(rx_sleep_o)) else $error("full set while asleep");
  AST_ERR_WITH_FULL: assert property ($rose(flags_o.noise_flag) ||
    $rose(flags_o.framing_error_flag) || $rose(flags_o.parity_error_flag) |->
    $rose(flags_o.rx_buffer_full_flag)) else $error("error flag without full");
  AST_OVERRUN_KEEP: assert property ($rose(flags_o.overrun_flag) |->
    $past(flags_o.rx_buffer_full_flag) && $stable(rx_data_o)) else $error("overrun wrong");
  AST_FULL_CLEAR: assert property ($fell(flags_o.rx_buffer_full_flag) |->
    $past(data_read_i)) else $error("full cleared without data read");
  AST_QUIET_CLEAR: assert property ($fell(flags_o.line_quiet_flag) |->
    $past(data_read_i)) else $error("quiet cleared without data read");
  AST_EDGE_CLEAR: assert property ($fell(flags_o.rx_edge_flag) |->
    $past(rx_edge_clear_i)) else $error("edge flag cleared without write");
  AST_RELEASED: assert property (!$past(rst_i) && !$past(stop_i) |->
    rxd_released_o == $past(ctrl_i.loop_enable)) else $error("input release wrong");
  AST_SW_DIR: assert property (!$past(rst_i) && !$past(stop_i) &&
    $past(ctrl_i.loop_enable && ctrl_i.rx_source_select) |->
    txd_oe_o == $past(ctrl_i.single_wire_direction)) else $error("single wire dir wrong");
  AST_STOP_HOLD: assert property (stop_i && $past(stop_i) |->
    $stable(rx_data_o) && $stable(rx_sleep_o)) else $error("state moved in stop");
endmodule : serial_rx_asserts

/* File: dv/serial_node.sv */
// Remote serial node driving the receive line
`timescale 1ns/1ps
module serial_node (
  input  wire logic clk_i,
  input  wire logic tick_i,
  output logic      line_o
);
  initial line_o = 1'b1;

  task automatic bit_time(input logic v);
    line_o = v;
    repeat (16) @(posedge clk_i iff tick_i);
    @(negedge clk_i);
  endtask : bit_time

  // Start low, data LSB first, chosen stop level, then idle high
  task automatic send(input logic [8:0] w, input logic nine, input logic stp);
    int i;
    bit_time(1'b0);
    for (i = 0; i < (nine ? 9 : 8); i++)
      bit_time(w[i]);
    bit_time(stp);
    line_o = 1'b1;
    @(negedge clk_i);
  endtask : send
endmodule : serial_node

/* File: dv/tb.sv */
// Self-checking bench of the serial receiver core
`timescale 1ns/1ps
module tb;
  logic                   clk_i, rst_i, sample_tick_i, stop_i, rx_sleep_set_i;
  logic                   status_read_i, data_read_i, rx_edge_clear_i, tx_valid_i;
  logic [7:0]             tx_data_i;
  logic                   tx_ready_o, rxd_i, txd_pin_i, txd_o, txd_oe_o, rxd_released_o;
  logic [8:0]             rx_data_o;
  logic                   rx_sleep_o, tx_irq_o, rx_irq_o, err_irq_o, wake_o, woke;
  serial_rx_pkg::ctrl_t   ctrl_i;
  serial_rx_pkg::irq_en_t irq_en_i;
  serial_rx_pkg::flags_t  flags_o;
  logic [1:0]             tdiv;
  int                     n_errors, samples_checked, cycles;

  assign txd_pin_i = txd_oe_o ? txd_o : rxd_i;

  serial_rx_core u_dut (.clk_i, .rst_i, .sample_tick_i, .stop_i, .ctrl_i, .irq_en_i,
    .rx_sleep_set_i, .status_read_i, .data_read_i, .rx_edge_clear_i, .tx_valid_i,
    .tx_data_i, .tx_ready_o, .rxd_i, .txd_pin_i, .txd_o, .txd_oe_o, .rxd_released_o,
    .rx_data_o, .flags_o, .rx_sleep_o, .tx_irq_o, .rx_irq_o, .err_irq_o, .wake_o);
  serial_node u_node (.clk_i(clk_i), .tick_i(sample_tick_i), .line_o(rxd_i));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  always @(negedge clk_i)
  begin
    tdiv <= tdiv + 2'h1;
    sample_tick_i <= (tdiv == 2'h3);
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (wake_o)
      woke <= 1'b1;
    if (cycles == 60000)
    begin
      n_errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (n_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask : pulse

  task automatic rd_clr();
    pulse(status_read_i);
    pulse(data_read_i);
  endtask : rd_clr

  task automatic idle(input int n);
    repeat (n * 64) @(negedge clk_i);
  endtask : idle

  initial
  begin
    {tdiv, sample_tick_i, stop_i, rx_sleep_set_i, status_read_i, data_read_i} = '0;
    {rx_edge_clear_i, tx_valid_i, tx_data_i, woke, cycles} = '0;
    ctrl_i = '0;
    irq_en_i = '1;
    rst_i = 1'b1;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    ctrl_i.rx_on = 1'b1;
    @(negedge clk_i);
    @(negedge clk_i);
    check("tx_irq", 9'h001, tx_irq_o);
    u_node.send(9'h0a5, 1'b0, 1'b1);
    check("rx_data", 9'h0a5, rx_data_o);
    check("full", 9'h001, flags_o.rx_buffer_full_flag);
    check("rx_irq", 9'h001, rx_irq_o);
    check("edge", 9'h001, flags_o.rx_edge_flag);
    pulse(rx_edge_clear_i);
    check("edge", 9'h000, flags_o.rx_edge_flag);
    rd_clr();
    check("full", 9'h000, flags_o.rx_buffer_full_flag);
    u_node.send(9'h011, 1'b0, 1'b1);
    u_node.send(9'h022, 1'b0, 1'b1);
    check("overrun", 9'h001, flags_o.overrun_flag);
    check("rx_data", 9'h011, rx_data_o);
    check("err_irq", 9'h001, err_irq_o);
    pulse(data_read_i);
    check("full", 9'h001, flags_o.rx_buffer_full_flag);
    rd_clr();
    u_node.send(9'h000, 1'b0, 1'b0);
    check("framing", 9'h001, flags_o.framing_error_flag);
    check("break", 9'h001, flags_o.lin_break_detect_flag);
    check("full", 9'h001, flags_o.rx_buffer_full_flag);
    rd_clr();
    idle(2);
    ctrl_i.nine_bit = 1'b1;
    ctrl_i.parity_en = 1'b1;
    u_node.send(9'h1c3, 1'b1, 1'b1);
    check("rx_data", 9'h1c3, rx_data_o);
    check("parity", 9'h001, flags_o.parity_error_flag);
    rd_clr();
    ctrl_i.nine_bit = 1'b0;
    ctrl_i.parity_en = 1'b0;
    ctrl_i.wake_method = 1'b1;
    pulse(rx_sleep_set_i);
    check("sleep", 9'h001, rx_sleep_o);
    u_node.send(9'h012, 1'b0, 1'b1);
    check("full", 9'h000, flags_o.rx_buffer_full_flag);
    check("sleep", 9'h001, rx_sleep_o);
    u_node.send(9'h085, 1'b0, 1'b1);
    check("sleep", 9'h000, rx_sleep_o);
    check("rx_data", 9'h085, rx_data_o);
    check("full", 9'h001, flags_o.rx_buffer_full_flag);
    rd_clr();
    ctrl_i.wake_method = 1'b0;
    pulse(rx_sleep_set_i);
    idle(13);
    check("sleep", 9'h000, rx_sleep_o);
    check("quiet", 9'h000, flags_o.line_quiet_flag);
    ctrl_i.sleep_quiet_detect_enable = 1'b1;
    u_node.send(9'h033, 1'b0, 1'b1);
    pulse(rx_sleep_set_i);
    idle(13);
    check("quiet", 9'h001, flags_o.line_quiet_flag);
    rd_clr();
    check("quiet", 9'h000, flags_o.line_quiet_flag);
    idle(13);
    check("quiet", 9'h000, flags_o.line_quiet_flag);
    stop_i = 1'b1;
    u_node.send(9'h0ff, 1'b0, 1'b1);
    check("wake", 9'h001, woke);
    check("full", 9'h000, flags_o.rx_buffer_full_flag);
    stop_i = 1'b0;
    ctrl_i.loop_enable = 1'b1;
    ctrl_i.tx_on = 1'b1;
    @(negedge clk_i);
    check("released", 9'h001, rxd_released_o);
    tx_data_i = 8'h3c;
    pulse(tx_valid_i);
    idle(22);
    check("rx_data", 9'h03c, rx_data_o);
    check("tx_done", 9'h001, flags_o.tx_done_flag);
    rd_clr();
    ctrl_i.nine_bit = 1'b1;
    ctrl_i.tx_ninth_bit = 1'b1;
    pulse(tx_valid_i);
    idle(13);
    check("rx_data", 9'h13c, rx_data_o);
    rd_clr();
    ctrl_i.nine_bit = 1'b0;
    ctrl_i.rx_source_select = 1'b1;
    @(negedge clk_i);
    @(negedge clk_i);
    check("txd_oe", 9'h000, txd_oe_o);
    u_node.send(9'h05a, 1'b0, 1'b1);
    check("rx_data", 9'h05a, rx_data_o);
    rd_clr();
    ctrl_i.single_wire_direction = 1'b1;
    ctrl_i.tx_on = 1'b0;
    irq_en_i.tx_done = 1'b0;
    @(negedge clk_i);
    @(negedge clk_i);
    check("txd_oe", 9'h001, txd_oe_o);
    tx_valid_i = 1'b1;
    repeat (20) @(negedge clk_i);
    tx_valid_i = 1'b0;
    check("tx_ready", 9'h000, tx_ready_o);
    check("tx_empty", 9'h000, flags_o.tx_buffer_empty_flag);
    check("tx_irq", 9'h000, tx_irq_o);
    ctrl_i.tx_on = 1'b1;
    idle(200);
    check("tx_ready", 9'h001, tx_ready_o);
    check("tx_done", 9'h001, flags_o.tx_done_flag);
    check("txd", 9'h001, txd_o);
    test_done();
  end
endmodule : tb

bind serial_rx_core serial_rx_asserts u_asserts (.clk_i, .rst_i, .stop_i, .ctrl_i,
  .irq_en_i, .data_read_i, .rx_edge_clear_i, .txd_oe_o, .rxd_released_o, .rx_data_o,
  .flags_o, .rx_sleep_o, .tx_irq_o, .rx_irq_o, .err_irq_o);
